//--- rtl/pm_serial_packet_status_pkg.sv
package pm_serial_packet_status_pkg;
   localparam int          ADDR_W           = 16;
   localparam logic [15:0] OFS_STATUS       = 16'h850C;
   localparam logic [15:0] OFS_CLOCK_STOP   = 16'h8508;
   localparam logic [15:0] OFS_TIMER_EN     = 16'h8510;
   localparam logic [15:0] OFS_DECODE_BASE  = 16'h8514;
   localparam logic [15:0] OFS_DECODE_MASK  = 16'h8518;
   localparam logic [15:0] OFS_IRQ_STATUS   = 16'h851C;
   localparam logic [15:0] OFS_IRQ_MASK     = 16'h8520;
   localparam int          BIT_VSYNC        = 7;
   localparam int          BIT_ACTIVITY     = 6;
   localparam int          BIT_DECODE       = 1;
   localparam int          BIT_CLOCK_STOP   = 0;
   localparam int          BIT_WRITE_CMP    = 1;
   localparam int          BIT_READ_CMP     = 0;
   localparam int          BIT_ACT_ENABLE   = 0;
   localparam int          ADR_HI           = 27;
   localparam int          ADR_LO           = 2;
   localparam logic [31:0] DECODE_FIELD     = 32'h0FFFFFFC;
   localparam logic [7:0]  STATUS_USED      = 8'hC2;
endpackage

//--- rtl/pm_serial_packet_status.sv
`timescale 1ns/1ns
`default_nettype none
module pm_serial_packet_status
   import pm_serial_packet_status_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        display_vertical_irq_flag_i,
   input  wire logic        display_vertical_irq_enable_i,
   input  wire logic        l1_miss_i,
   input  wire logic        l1_miss_ifetch_i,
   input  wire logic        mem_access_i,
   input  wire logic        mem_write_i,
   input  wire logic [31:0] mem_addr_i,
   output logic             vsync_event_flag_o,
   output logic             processor_activity_flag_o,
   output logic             decode_hit_flag_o,
   output logic             keep_clocks_running_o,
   output logic             irq_o
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   logic        suspend_clock_stop_select_r;
   logic [31:0] pm_timer_enable_control_r;
   logic [31:0] pm_decode_base_r;
   logic [31:0] pm_decode_mask_r;
   logic [7:0]  status_r;
   logic [7:0]  irq_status_r;
   logic [7:0]  irq_mask_r;
   logic        ack_r;
   logic [31:0] rdata_r;

   logic        req;
   logic        wr_acc;
   logic        vsync_ev;
   logic        act_ev;
   logic        decode_ev;
   logic        addr_match;
   logic        type_match;
   logic [7:0]  events;

   assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_acc = req & wb_we_i;

   // ****************************************************************
   // event detection
   // ****************************************************************
   // flag and enable both gate the report
   assign vsync_ev = display_vertical_irq_flag_i
                   & display_vertical_irq_enable_i;
   assign act_ev   = l1_miss_i & ~l1_miss_ifetch_i
                   & pm_timer_enable_control_r[BIT_ACT_ENABLE];
   // masked bits always match; only bits 27:2 take part
   assign addr_match = (((pm_decode_base_r ^ mem_addr_i) & ~pm_decode_mask_r)
                        & DECODE_FIELD) == 32'h00000000;
   assign type_match = mem_write_i ? pm_decode_mask_r[BIT_WRITE_CMP]
                                   : pm_decode_mask_r[BIT_READ_CMP];
   assign decode_ev = mem_access_i & type_match & addr_match;

   always_comb begin
      events               = 8'h00;
      events[BIT_VSYNC]    = vsync_ev;
      events[BIT_ACTIVITY] = act_ev;
      events[BIT_DECODE]   = decode_ev;
   end

   // ****************************************************************
   // status flags
   // ****************************************************************
   // status is event-driven only; bus writes never reach it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= 8'h00;
      end else begin
         status_r <= events & STATUS_USED;
      end
   end

   // sticky copy for interrupts: set wins over write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_r <= 8'h00;
      end else if (wr_acc && wb_adr_i == OFS_IRQ_STATUS && wb_sel_i[0]) begin
         irq_status_r <= (irq_status_r & ~wb_dat_i[7:0]) | events;
      end else begin
         irq_status_r <= irq_status_r | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status_r & irq_mask_r);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vsync_event_flag_o        <= 1'b0;
         processor_activity_flag_o <= 1'b0;
         decode_hit_flag_o         <= 1'b0;
      end else begin
         vsync_event_flag_o        <= vsync_ev;
         processor_activity_flag_o <= act_ev;
         decode_hit_flag_o         <= decode_ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_clocks_running_o <= 1'b1;
      end else begin
         keep_clocks_running_o <= ~suspend_clock_stop_select_r;
      end
   end

   // ****************************************************************
   // control register writes
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         suspend_clock_stop_select_r <= 1'b0;
         pm_timer_enable_control_r   <= 32'h00000000;
         pm_decode_base_r            <= 32'h00000000;
         pm_decode_mask_r            <= 32'h00000000;
         irq_mask_r                  <= 8'h00;
      end else if (wr_acc) begin
         case (wb_adr_i)
            OFS_CLOCK_STOP: begin
               if (wb_sel_i[0]) begin
                  suspend_clock_stop_select_r <= wb_dat_i[BIT_CLOCK_STOP];
               end
            end
            OFS_TIMER_EN: begin
               pm_timer_enable_control_r <=
                  merge_sel(pm_timer_enable_control_r, wb_dat_i, wb_sel_i);
            end
            OFS_DECODE_BASE: begin
               // any address in the field is accepted
               pm_decode_base_r <= merge_sel(pm_decode_base_r, wb_dat_i,
                                             wb_sel_i) & DECODE_FIELD;
            end
            OFS_DECODE_MASK: begin
               pm_decode_mask_r <= merge_sel(pm_decode_mask_r, wb_dat_i,
                                             wb_sel_i)
                                 & (DECODE_FIELD | 32'h00000003);
            end
            OFS_IRQ_MASK: begin
               if (wb_sel_i[0]) begin
                  irq_mask_r <= wb_dat_i[7:0] & STATUS_USED;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // bus answer
   // ****************************************************************
   // one-cycle answer; ack drops the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r <= req;
         if (req) begin
            case (wb_adr_i)
               OFS_STATUS:      rdata_r <= {24'h000000, status_r};
               OFS_CLOCK_STOP:  rdata_r <= {31'h00000000,
                                            suspend_clock_stop_select_r};
               OFS_TIMER_EN:    rdata_r <= pm_timer_enable_control_r;
               OFS_DECODE_BASE: rdata_r <= pm_decode_base_r;
               OFS_DECODE_MASK: rdata_r <= pm_decode_mask_r;
               OFS_IRQ_STATUS:  rdata_r <= {24'h000000, irq_status_r};
               OFS_IRQ_MASK:    rdata_r <= {24'h000000, irq_mask_r};
               default:         rdata_r <= 32'h00000000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

endmodule
`default_nettype wire

//--- verif/pm_status_props.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// port checks
// ***
module pm_status_props
   import pm_serial_packet_status_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        display_vertical_irq_flag_i,
   input wire logic        display_vertical_irq_enable_i,
   input wire logic        l1_miss_i,
   input wire logic        l1_miss_ifetch_i,
   input wire logic        mem_access_i,
   input wire logic        vsync_event_flag_o,
   input wire logic        processor_activity_flag_o,
   input wire logic        decode_hit_flag_o,
   input wire logic        keep_clocks_running_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_vsync_mirror: assert property (
      $past(!rst_i) |-> vsync_event_flag_o == $past(
      display_vertical_irq_flag_i & display_vertical_irq_enable_i))
      else $error("vsync flag does not follow its cause");
   a_act_no_fetch: assert property (
      processor_activity_flag_o |-> $past(l1_miss_i && !l1_miss_ifetch_i))
      else $error("activity flag without data miss");
   a_decode_needs_access: assert property (
      decode_hit_flag_o |-> $past(mem_access_i))
      else $error("decode flag without memory access");
   a_ack_follows_req: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_req: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_status_zeros: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == OFS_STATUS
      |-> (wb_dat_o & ~{24'h000000, STATUS_USED}) == 32'h00000000)
      else $error("status reserved bits not zero");
   a_keep_clocks: assert property (
      wb_ack_o && wb_we_i && wb_adr_i == OFS_CLOCK_STOP && wb_sel_i[0]
      |=> keep_clocks_running_o == !$past(wb_dat_i[0]))
      else $error("keep clocks output wrong");
   c_vsync: cover property (vsync_event_flag_o);
   c_decode: cover property (decode_hit_flag_o);
   c_irq: cover property (irq_o);
endmodule
bind pm_serial_packet_status pm_status_props i_pm_status_props (.*);
`default_nettype wire

//--- verif/pm_packet_receiver.sv
`timescale 1ns/1ns
`default_nettype none
module pm_packet_receiver (
   input  wire logic       clk_i,
   input  wire logic [2:0] packet_i,
   output logic      [2:0] packet_o
);
   // takes the packet bits one cycle late, as a companion would
   always_ff @(posedge clk_i) begin
      packet_o <= packet_i;
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import pm_serial_packet_status_pkg::*;
   logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0, l1_miss_i = 1'h0, l1_miss_ifetch_i = 1'h0;
   logic display_vertical_irq_flag_i = 1'h0, mem_access_i = 1'h0;
   logic display_vertical_irq_enable_i = 1'h0, mem_write_i = 1'h0;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, mem_addr_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, vsync_event_flag_o, processor_activity_flag_o;
   logic decode_hit_flag_o, keep_clocks_running_o, irq_o;
   logic [2:0]  pkt;
   int num_errors = 0, samples_checked = 0;
   // never stopped, the companion needs it
   always #10 clk_i = ~clk_i;
   pm_serial_packet_status i_pm_serial_packet_status (.*);
   pm_packet_receiver i_pm_packet_receiver (.clk_i(clk_i), .packet_o(pkt),
      .packet_i({vsync_event_flag_o, processor_activity_flag_o,
                 decode_hit_flag_o}));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (n >= 20) begin
         num_errors++;
         print_verdict();
      end
   endtask
   task automatic pkt_chk(input logic [2:0] exp);
      repeat (2) @(posedge clk_i);
      #1 chk({29'h0, pkt}, {29'h0, exp});
   endtask
   task automatic t_regs;
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      wb_sel_i <= 4'h1; // upper bytes never written
      wb(1'h1, OFS_STATUS, 32'hFF);
      wb_sel_i <= 4'hF;
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      wb(1'h0, 16'h8600, 32'h0);
      chk(q, 32'h0);
      wb(1'h1, OFS_CLOCK_STOP, 32'h1);
      pkt_chk(3'h0);
      chk({31'h0, keep_clocks_running_o}, 32'h0);
      wb(1'h1, OFS_CLOCK_STOP, 32'h0);
      pkt_chk(3'h0);
      chk({31'h0, keep_clocks_running_o}, 32'h1);
   endtask
   task automatic t_vsync;
      @(posedge clk_i);
      display_vertical_irq_flag_i <= 1'h1;
      pkt_chk(3'h0);
      @(posedge clk_i);
      display_vertical_irq_enable_i <= 1'h1;
      pkt_chk(3'h4);
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h80);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'h1, OFS_IRQ_MASK, 32'h80);
      display_vertical_irq_flag_i <= 1'h0;
      pkt_chk(3'h0);
      chk({31'h0, irq_o}, 32'h1);
      wb(1'h1, OFS_IRQ_STATUS, 32'h80);
      pkt_chk(3'h0);
      chk({31'h0, irq_o}, 32'h0);
   endtask
   task automatic t_act;
      @(posedge clk_i);
      l1_miss_i <= 1'h1;
      pkt_chk(3'h0);
      wb(1'h1, OFS_TIMER_EN, 32'h1);
      pkt_chk(3'h2);
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h40);
      @(posedge clk_i);
      l1_miss_ifetch_i <= 1'h1;
      pkt_chk(3'h0);
      @(posedge clk_i);
      l1_miss_i <= 1'h0;
   endtask
   task automatic t_decode;
      wb(1'h1, OFS_DECODE_BASE, 32'h0ABCD5A0);
      wb(1'h1, OFS_DECODE_MASK, 32'h000000F2);
      {mem_access_i, mem_write_i} <= 2'h3;
      mem_addr_i <= 32'h0ABCD550;
      pkt_chk(3'h1);
      wb(1'h0, OFS_STATUS, 32'h0);
      chk(q, 32'h2);
      @(posedge clk_i);
      mem_write_i <= 1'h0;
      pkt_chk(3'h0);
      wb(1'h1, OFS_DECODE_MASK, 32'h000000F1);
      pkt_chk(3'h1);
      @(posedge clk_i);
      mem_addr_i <= 32'h0ABCD554;
      pkt_chk(3'h0);
      @(posedge clk_i);
      mem_access_i <= 1'h0;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      t_regs();
      t_vsync();
      t_act();
      t_decode();
      print_verdict();
   end
endmodule
`default_nettype wire
